// ==== dcs_safety_input.sv ====
`timescale 1ns/100ps
// Behaviour
// [R01] Commands come only from wired pairs, never network.
// [R02] Each pair carries its selected command.
// [R03] Fourteen assignable commands from torque-off to torque limits.
// [R04] Pair drives axis A only or A, B, C.
// [R05] Auto-activated commands are on regardless of inputs.
// [R06] Disagreeing channels force the command off.
// [R07] Command on only when both channels on.
// [R08] Mismatch beyond limit raises alarm and stop category 1.
// [R09] Source switches both channels within mismatch time.
// [R10] Startup diagnosis toggles each selected input individually.
// [R11] Test pulses go off; inputs must follow.
// [R12] Every input passes a noise filter first.
// [R13] User checks output devices at least daily.
// [R14] Zero mismatch time disables mismatch diagnosis.
// [R15] Two test pulses never off together; configurable width.
// [R16] Finished startup diagnosis clears warning, releases torque-off.
// [R17] Test-pulse fault raises input diagnosis alarm.
// [R18] Filter passes level only after stable filter time.
// [R19] Mismatch timer restarts when channels agree.
module dcs_safety_input import dcs_pkg::*; #(
    parameter logic [MMW-1:0] PULSE_PERIOD = 16'h0064
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic safe_in_pair1_chan_a,
    input wire logic safe_in_pair1_chan_b,
    input wire logic safe_in_pair2_chan_a,
    input wire logic safe_in_pair2_chan_b,
    input wire logic safe_in_pair3_chan_a,
    input wire logic safe_in_pair3_chan_b,
    output logic test_pulse_out_a,
    output logic test_pulse_out_b,
    output logic [NCMD-1:0] cmd_axis_a,
    output logic [NCMD-1:0] cmd_axis_bc,
    output logic startup_warning,
    output logic input_mismatch_alarm,
    output logic input_diag_alarm,
    output logic irq
);
    localparam logic [TDW-1:0] TDIV_LAST = TDW'(TICK_CYCLES - 1);
    localparam logic [MMW-1:0] P_HALF = PULSE_PERIOD >> 1;

    function automatic logic [NCMD-1:0] sel_onehot(input logic [SELW-1:0] s, input logic en);
        sel_onehot = '0;
        if (en && s != 4'h0 && s <= SELW'(NCMD)) begin
            sel_onehot = NCMD'(1) << (s - 4'h1);
        end
    endfunction : sel_onehot

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] strb, input logic [31:0] m);
        logic [31:0] bm;
        bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & m;
        wmerge = (old & ~bm) | (d & bm);
    endfunction : wmerge

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = a <= REG_CTRL;
    endfunction : is_mapped

    logic aw_got_r, w_got_r, ar_got_r, awready_r, wready_r, arready_r, bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] wdata_r, rdata_r, rd_word;
    logic [3:0] wstrb_r;
    logic [ADDR_W-1:0] awaddr_r, araddr_r;
    logic [31:0] func_r, auto_r, diag_r, mm01_r, mm2_r, mask_r, ctrl_r;
    logic [IRQW-1:0] irq_stat_r, irq_stat_nxt, irq_ev;
    logic irq_r, wr_fire, rd_fire, alm_clr;
    logic [TDW-1:0] tdiv_r;
    logic tick_r;
    logic [2*NPAIR-1:0] raw, filt_r;
    logic [FTW-1:0] fcnt_r [2*NPAIR];
    logic [NPAIR-1:0] raw_a, raw_b, filt_a, filt_b, pair_on, assigned, mm_hit, dg_ok;
    logic [MMW-1:0] mm_time [NPAIR];
    logic [MMW-1:0] mm_cnt_r [NPAIR];
    dcs_diag_t dg_st_r [NPAIR];
    logic [MMW-1:0] pp_r, off_eff;
    logic tpa_r, tpb_r, chk_a, chk_b, pd_fault;
    logic mis_alm_r, diag_alm_r, done_r, start_ok, warn_r;
    logic [NCMD-1:0] cmd_a_r, cmd_bc_r, cmd_a_nxt, cmd_bc_nxt;

    assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
    assign rd_fire = ar_got_r && !rvalid_r;
    assign alm_clr = wr_fire && awaddr_r == REG_CTRL && wstrb_r[0] && wdata_r[CTRL_CLR_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            awready_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axi_awvalid && awready_r) begin
            aw_got_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
        end else if (wr_fire) begin
            aw_got_r <= 1'b0;
        end else if (!aw_got_r) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_r <= 1'b0;
            wready_r <= 1'b0;
            wdata_r <= RST_WORD;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && wready_r) begin
            w_got_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_got_r <= 1'b0;
        end else if (!w_got_r) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            func_r <= RST_WORD;
            auto_r <= RST_WORD;
            diag_r <= RST_WORD;
            mm01_r <= RST_WORD;
            mm2_r <= RST_WORD;
            mask_r <= RST_WORD;
            ctrl_r <= RST_WORD;
        end else if (wr_fire) begin
            case (awaddr_r)
                REG_FUNC_SEL: func_r <= wmerge(func_r, wdata_r, wstrb_r, MASK_FUNC);
                REG_AUTO_ACT: auto_r <= wmerge(auto_r, wdata_r, wstrb_r, MASK_AUTO);
                REG_DIAG_CFG: diag_r <= wmerge(diag_r, wdata_r, wstrb_r, MASK_DIAG);
                REG_MM_TIME01: mm01_r <= wmerge(mm01_r, wdata_r, wstrb_r, MASK_MM01);
                REG_MM_TIME2: mm2_r <= wmerge(mm2_r, wdata_r, wstrb_r, MASK_MM2);
                REG_IRQ_MASK: mask_r <= wmerge(mask_r, wdata_r, wstrb_r, MASK_IRQ);
                REG_CTRL: ctrl_r <= wmerge(ctrl_r, wdata_r, wstrb_r, MASK_CTRL);
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_word = RST_WORD;
        case (araddr_r)
            REG_FUNC_SEL: rd_word = func_r;
            REG_AUTO_ACT: rd_word = auto_r;
            REG_DIAG_CFG: rd_word = diag_r;
            REG_MM_TIME01: rd_word = mm01_r;
            REG_MM_TIME2: rd_word = mm2_r;
            REG_STATUS: begin
                rd_word[NCMD-1:0] = cmd_a_r;
                rd_word[ST_MIS_LSB +: NPAIR] = filt_a ^ filt_b;
                rd_word[ST_PEND_BIT] = !done_r;
                rd_word[ST_MALM_BIT] = mis_alm_r;
                rd_word[ST_DALM_BIT] = diag_alm_r;
            end
            REG_IRQ_STAT: rd_word[IRQW-1:0] = irq_stat_r;
            REG_IRQ_MASK: rd_word = mask_r;
            REG_CTRL: rd_word = ctrl_r;
            default: ;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_got_r <= 1'b0;
            arready_r <= 1'b0;
            araddr_r <= '0;
            rvalid_r <= 1'b0;
            rdata_r <= RST_WORD;
            rresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && arready_r) begin
                ar_got_r <= 1'b1;
                arready_r <= 1'b0;
                araddr_r <= {s_axi_araddr[ADDR_W-1:2], 2'h0};
            end else if (rd_fire) begin
                ar_got_r <= 1'b0;
            end else if (!ar_got_r) begin
                arready_r <= 1'b1;
            end
            if (rd_fire) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= is_mapped(araddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Status bits are sticky; a new event in the clearing read cycle survives.
    assign irq_ev[IRQ_MIS] = (|mm_hit) && !mis_alm_r;
    assign irq_ev[IRQ_DIAG] = pd_fault && !diag_alm_r;
    assign irq_ev[IRQ_START] = start_ok && !done_r;
    assign irq_stat_nxt = ((rd_fire && araddr_r == REG_IRQ_STAT) ? '0 : irq_stat_r) | irq_ev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_nxt & mask_r[IRQW-1:0]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tdiv_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= tdiv_r == TDIV_LAST;
            tdiv_r <= (tdiv_r == TDIV_LAST) ? '0 : tdiv_r + 1'b1;
        end
    end

    assign raw_a = {safe_in_pair3_chan_a, safe_in_pair2_chan_a, safe_in_pair1_chan_a};
    assign raw_b = {safe_in_pair3_chan_b, safe_in_pair2_chan_b, safe_in_pair1_chan_b};
    assign raw = {raw_b, raw_a};
    assign filt_a = filt_r[NPAIR-1:0];
    assign filt_b = filt_r[2*NPAIR-1:NPAIR];
    assign pair_on = filt_a & filt_b; // see [R07]
    assign mm_time[0] = mm01_r[MM_LSB0 +: MMW];
    assign mm_time[1] = mm01_r[MM_LSB1 +: MMW];
    assign mm_time[2] = mm2_r[MM_LSB0 +: MMW];

    for (genvar c = 0; c < 2 * NPAIR; c++) begin : g_filt
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                filt_r[c] <= 1'b0;
                fcnt_r[c] <= '0;
            end else if (raw[c] == filt_r[c]) begin
                fcnt_r[c] <= '0; // see [R12]
            end else if (tick_r) begin
                if (fcnt_r[c] >= diag_r[DC_FILT_LSB +: FTW]) begin
                    filt_r[c] <= raw[c]; // see [R18]
                    fcnt_r[c] <= '0;
                end else begin
                    fcnt_r[c] <= fcnt_r[c] + 1'b1;
                end
            end
        end
    end

    for (genvar i = 0; i < NPAIR; i++) begin : g_pair
        assign assigned[i] = func_r[i*SELW +: SELW] != 4'h0;
        assign mm_hit[i] = (filt_a[i] ^ filt_b[i]) && mm_time[i] != '0
                           && mm_cnt_r[i] >= mm_time[i]; // see [R08] [R14]
        assign dg_ok[i] = !(assigned[i] && diag_r[DC_START_LSB+i]) || dg_st_r[i] == DG_DONE;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mm_cnt_r[i] <= '0;
            end else if (!(filt_a[i] ^ filt_b[i]) || mm_time[i] == '0 || !dg_ok[i]) begin
                mm_cnt_r[i] <= '0; // see [R19] [R14]
            end else if (tick_r && mm_cnt_r[i] != '1) begin
                mm_cnt_r[i] <= mm_cnt_r[i] + 1'b1; // see [R06]
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                dg_st_r[i] <= DG_A_OFF;
            end else begin
                case (dg_st_r[i])
                    DG_A_OFF: if (ctrl_r[CTRL_ARM_BIT] && !filt_a[i] && filt_b[i]) begin
                        dg_st_r[i] <= DG_A_ON; // see [R10]
                    end
                    DG_A_ON: if (pair_on[i]) begin
                        dg_st_r[i] <= DG_B_OFF;
                    end
                    DG_B_OFF: if (filt_a[i] && !filt_b[i]) begin
                        dg_st_r[i] <= DG_B_ON;
                    end
                    DG_B_ON: if (pair_on[i]) begin
                        dg_st_r[i] <= DG_DONE;
                    end
                    DG_DONE: dg_st_r[i] <= DG_DONE;
                    default: dg_st_r[i] <= DG_A_OFF;
                endcase
            end
        end
    end

    // Off windows sit in opposite halves of the period and never overlap.
    assign off_eff = (MMW'(diag_r[DC_OFF_LSB +: FTW]) >= P_HALF) ? P_HALF - 16'h0001
                     : MMW'(diag_r[DC_OFF_LSB +: FTW]); // see [R15]
    assign chk_a = tick_r && off_eff != '0 && pp_r == off_eff - 16'h0001;
    assign chk_b = tick_r && off_eff != '0 && pp_r == P_HALF + off_eff - 16'h0001;
    assign pd_fault = |(diag_r[DC_PULSE_LSB +: NPAIR] & assigned
                        & (({NPAIR{chk_a}} & raw_a & filt_a) | ({NPAIR{chk_b}} & raw_b & filt_b)));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pp_r <= '0;
            tpa_r <= 1'b1;
            tpb_r <= 1'b1;
        end else begin
            if (tick_r) begin
                pp_r <= (pp_r == PULSE_PERIOD - 16'h0001) ? '0 : pp_r + 16'h0001;
            end
            tpa_r <= !(pp_r < off_eff); // see [R11]
            tpb_r <= !(pp_r >= P_HALF && pp_r < P_HALF + off_eff);
        end
    end

    assign start_ok = ctrl_r[CTRL_ARM_BIT] && (&dg_ok) && (&(~assigned | pair_on));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mis_alm_r <= 1'b0;
            diag_alm_r <= 1'b0;
            done_r <= 1'b0;
            warn_r <= 1'b1;
        end else begin
            mis_alm_r <= (|mm_hit) || (mis_alm_r && !alm_clr); // see [R08]
            diag_alm_r <= pd_fault || (diag_alm_r && !alm_clr); // see [R17]
            done_r <= done_r || start_ok; // see [R16]
            warn_r <= !(done_r || start_ok); // see [R16]
        end
    end

    // Only the wired pairs, auto selections, the mismatch alarm and pending startup build commands.
    always_comb begin
        cmd_a_nxt = auto_r[NCMD-1:0]; // see [R05] [R01]
        cmd_a_nxt[CMD_STOP_CAT1] = cmd_a_nxt[CMD_STOP_CAT1] | mis_alm_r;
        cmd_a_nxt[CMD_TORQUE_OFF] = cmd_a_nxt[CMD_TORQUE_OFF] | !done_r;
        cmd_bc_nxt = cmd_a_nxt;
        for (int i = 0; i < NPAIR; i++) begin
            cmd_a_nxt = cmd_a_nxt | sel_onehot(func_r[i*SELW +: SELW], pair_on[i]); // see [R02] [R03]
            cmd_bc_nxt = cmd_bc_nxt | sel_onehot(func_r[i*SELW +: SELW],
                                                 pair_on[i] && func_r[FS_AXIS_LSB+i]); // see [R04]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_a_r <= '0;
            cmd_bc_r <= '0;
        end else begin
            cmd_a_r <= cmd_a_nxt;
            cmd_bc_r <= cmd_bc_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign test_pulse_out_a = tpa_r;
    assign test_pulse_out_b = tpb_r;
    assign cmd_axis_a = cmd_a_r;
    assign cmd_axis_bc = cmd_bc_r;
    assign startup_warning = warn_r;
    assign input_mismatch_alarm = mis_alm_r;
    assign input_diag_alarm = diag_alm_r;
    assign irq = irq_r;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_dg_enter_b;
        dg_st_r[0] == DG_A_ON ##1 dg_st_r[0] == DG_B_OFF;
    endsequence

    a_pair_both_on: assert property ((pair_on[0] && func_r[SELW-1:0] != 4'h0 // see [R07]
        && func_r[SELW-1:0] <= SELW'(NCMD)) |=> cmd_a_r[$past(func_r[SELW-1:0]) - 4'h1])
        else $error("Pair one on but its command is off.");
    a_mismatch_off: assert property ((filt_a[0] != filt_b[0] && func_r[SELW-1:0] == 4'h4 // see [R06]
        && func_r[2*SELW-1:SELW] != 4'h4 && func_r[3*SELW-1:2*SELW] != 4'h4
        && !auto_r[CMD_LIM_SPEED_1]) |=> !cmd_a_r[CMD_LIM_SPEED_1])
        else $error("Mismatched pair still drives its command.");
    a_auto_active: assert property (1'b1 |=> (cmd_a_r & $past(auto_r[NCMD-1:0])) // see [R05]
        == $past(auto_r[NCMD-1:0])) else $error("Auto command not active.");
    a_alarm_stop1: assert property ((|mm_hit) |=> input_mismatch_alarm ##1 cmd_axis_a[CMD_STOP_CAT1]) // see [R08]
        else $error("Mismatch timeout did not stop.");
    a_zero_disable: assert property (mm_time[0] == '0 |=> !mm_hit[0]) // see [R14]
        else $error("Zero mismatch time still diagnoses.");
    a_timer_restart: assert property ((filt_a[1] == filt_b[1]) |=> mm_cnt_r[1] == '0) // see [R19]
        else $error("Mismatch timer not restarted.");
    a_pulse_apart: assert property (!(!test_pulse_out_a && !test_pulse_out_b)) // see [R15]
        else $error("Both test pulses off together.");
    a_diag_alarm: assert property (pd_fault |=> input_diag_alarm) // see [R17]
        else $error("Pulse fault without alarm.");
    a_startup_sto: assert property ((!done_r && !start_ok) // see [R16]
        |=> cmd_axis_a[CMD_TORQUE_OFF] && startup_warning)
        else $error("Torque-off released before startup.");
    a_bc_subset: assert property ((cmd_axis_bc & ~cmd_axis_a) == '0) // see [R04]
        else $error("Axis B/C command not on axis A.");
    a_toggle_order: assert property (s_dg_enter_b |-> $past(pair_on[0])) // see [R10]
        else $error("Startup step skipped re-closing A.");
    a_filter_hold: assert property ((raw[0] == filt_r[0]) |=> $stable(filt_r[0])) // see [R18]
        else $error("Filter output moved on steady input.");

endmodule : dcs_safety_input

// ==== dcs_pkg.sv ====
package dcs_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS = 100000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TDW = $clog2(TICK_CYCLES);
    localparam int NPAIR = 3;
    localparam int NCMD = 14;
    localparam int SELW = 4;
    localparam int MMW = 16;
    localparam int FTW = 8;
    localparam int ADDR_W = 8;
    localparam int IRQW = 3;
    // Command bit positions; code in a function select field is bit index plus one.
    localparam int CMD_TORQUE_OFF = 0;
    localparam int CMD_STOP_CAT1 = 1;
    localparam int CMD_STOP_CAT2 = 2;
    localparam int CMD_LIM_SPEED_1 = 3;
    localparam int CMD_DIR_POS = 7;
    localparam int CMD_DIR_NEG = 8;
    localparam int CMD_LIM_INC = 9;
    localparam int CMD_LIM_TORQUE_1 = 10;
    localparam logic [ADDR_W-1:0] REG_FUNC_SEL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_AUTO_ACT = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DIAG_CFG = 8'h08;
    localparam logic [ADDR_W-1:0] REG_MM_TIME01 = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_MM_TIME2 = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h20;
    localparam int FS_AXIS_LSB = 12;
    localparam int DC_START_LSB = 0;
    localparam int DC_PULSE_LSB = 4;
    localparam int DC_OFF_LSB = 8;
    localparam int DC_FILT_LSB = 16;
    localparam int MM_LSB0 = 0;
    localparam int MM_LSB1 = 16;
    localparam int ST_MIS_LSB = 14;
    localparam int ST_PEND_BIT = 17;
    localparam int ST_MALM_BIT = 18;
    localparam int ST_DALM_BIT = 19;
    localparam int IRQ_MIS = 0;
    localparam int IRQ_DIAG = 1;
    localparam int IRQ_START = 2;
    localparam int CTRL_ARM_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic [31:0] MASK_FUNC = 32'h0000_7fff;
    localparam logic [31:0] MASK_AUTO = 32'h0000_3fff;
    localparam logic [31:0] MASK_DIAG = 32'h00ff_ff77;
    localparam logic [31:0] MASK_MM01 = 32'hffff_ffff;
    localparam logic [31:0] MASK_MM2 = 32'h0000_ffff;
    localparam logic [31:0] MASK_IRQ = 32'h0000_0007;
    localparam logic [31:0] MASK_CTRL = 32'h0000_0001;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {DG_A_OFF, DG_A_ON, DG_B_OFF, DG_B_ON, DG_DONE} dcs_diag_t;
endpackage : dcs_pkg

// ==== dcs_switch_model.sv ====
`timescale 1ns/100ps
// Dual-channel switch fed from the test pulse outputs; an open contact reads off.
// A stuck channel A models a short to the supply that hides the off-pulses.
module dcs_switch_model (
    input wire logic close_a,
    input wire logic close_b,
    input wire logic pulse_a,
    input wire logic pulse_b,
    input wire logic stuck_a,
    output logic chan_a,
    output logic chan_b
);
    assign chan_a = close_a & (pulse_a | stuck_a);
    assign chan_b = close_b & pulse_b;
endmodule : dcs_switch_model

// ==== dual_channel_safety_input_test.sv ====
`timescale 1ns/100ps
module dual_channel_safety_input_test import dcs_pkg::*;;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, close_a = 0, close_b = 0, stuck_a = 0;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, code, fbit;
    logic awready, wready, bvalid, arready, rvalid, pa, pb, c1a, c1b;
    logic warn, malm, dalm, irq;
    logic [1:0] bresp, rresp;
    logic [13:0] cmd_a, cmd_bc;
    logic [1:0] wq[$];
    logic [33:0] rq[$];
    int errors = 0, num_checks = 0, seed = 32'h90f33181, n, na = 0, nb = 0, nab = 0;
    localparam logic [31:0] AUTO = 32'h1 << CMD_LIM_TORQUE_1;
    always #25 aclk = ~aclk;
    dcs_safety_input #(.PULSE_PERIOD(16'h0004)) u_dcs_safety_input (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .safe_in_pair1_chan_a(c1a), .safe_in_pair1_chan_b(c1b),
        .safe_in_pair2_chan_a(1'b0), .safe_in_pair2_chan_b(1'b0),
        .safe_in_pair3_chan_a(1'b0), .safe_in_pair3_chan_b(1'b0),
        .test_pulse_out_a(pa), .test_pulse_out_b(pb), .cmd_axis_a(cmd_a),
        .cmd_axis_bc(cmd_bc), .startup_warning(warn), .input_mismatch_alarm(malm),
        .input_diag_alarm(dalm), .irq(irq));
    dcs_switch_model u_dcs_switch_model (.close_a(close_a), .close_b(close_b),
        .pulse_a(pa), .pulse_b(pb), .stuck_a(stuck_a), .chan_a(c1a), .chan_b(c1b));
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    always @(posedge aclk) begin
        if (bvalid && bready) chk("bresp", {32'h0, wq.pop_front()}, {32'h0, bresp});
        if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pw, pd;
        @(posedge aclk);
        wq.push_back(RESP_OKAY);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        pw = 1'b1;
        pd = 1'b1;
        while (pw || pd) begin
            @(posedge aclk);
            if (pw && awready) begin
                pw = 1'b0;
                awvalid <= 1'b0;
            end
            if (pd && wready) begin
                pd = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask : rd
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (90000) @(posedge aclk);
        errors++;
        close_out();
    end
    initial begin
        code = 1 + {$random(seed)} % 10;
        fbit = 32'h1 << (code - 1);
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(REG_STATUS, {RESP_OKAY, 32'h1 | 32'h1 << ST_PEND_BIT});
        wr(REG_FUNC_SEL, code);
        rd(REG_FUNC_SEL, {RESP_OKAY, code});
        rd(8'h24, {RESP_SLVERR, 32'h0});
        wr(REG_AUTO_ACT, AUTO);
        wr(REG_MM_TIME01, 32'h2);
        wr(REG_IRQ_MASK, 32'h1);
        rd(REG_STATUS, {RESP_OKAY, 32'h1 | AUTO | 32'h1 << ST_PEND_BIT});
        $display("test config done");
        @(posedge aclk);
        close_a <= 1'b1;
        close_b <= 1'b1;
        wr(REG_CTRL, 32'h1);
        n = 0;
        while (warn !== 1'b0 && n < 20000) begin
            @(posedge aclk);
            n++;
        end
        chk("warn", 34'h0, {33'h0, warn});
        rd(REG_STATUS, {RESP_OKAY, fbit | AUTO});
        rd(REG_IRQ_STAT, {RESP_OKAY, 32'h4});
        rd(REG_IRQ_STAT, {RESP_OKAY, 32'h0});
        chk("cmd_bc", {2'h0, AUTO}, {20'h0, cmd_bc});
        $display("test startup done");
        @(posedge aclk);
        close_b <= 1'b0;
        n = 0;
        while (malm !== 1'b1 && n < 20000) begin
            @(posedge aclk);
            n++;
        end
        chk("malm", 34'h1, {33'h0, malm});
        rd(REG_STATUS, {RESP_OKAY, AUTO | 32'h1 << CMD_STOP_CAT1
            | 32'h1 << ST_MIS_LSB | 32'h1 << ST_MALM_BIT});
        chk("irq", 34'h1, {33'h0, irq});
        @(posedge aclk);
        close_b <= 1'b1;
        repeat (5000) @(posedge aclk);
        rd(REG_IRQ_STAT, {RESP_OKAY, 32'h1});
        repeat (3) @(posedge aclk);
        chk("irq", 34'h0, {33'h0, irq});
        wr(REG_CTRL, 32'h3);
        rd(REG_STATUS, {RESP_OKAY, fbit | AUTO});
        $display("test mismatch done");
        wstrb <= 4'h2;
        wr(REG_FUNC_SEL, 32'h1 << FS_AXIS_LSB);
        wstrb <= 4'hf;
        repeat (2) @(posedge aclk);
        chk("cmd_bc", {2'h0, fbit | AUTO}, {20'h0, cmd_bc});
        wr(REG_DIAG_CFG, 32'h1 << DC_PULSE_LSB | 32'h1 << DC_OFF_LSB
            | 32'h1 << DC_FILT_LSB);
        repeat (8000) begin
            @(posedge aclk);
            na += !pa;
            nb += !pb;
            nab += !pa && !pb;
        end
        chk("pulse_a", 34'(TICK_CYCLES), 34'(na));
        chk("pulse_b", 34'(TICK_CYCLES), 34'(nb));
        chk("pulse_both", 34'h0, 34'(nab));
        rd(REG_STATUS, {RESP_OKAY, fbit | AUTO});
        stuck_a <= 1'b1;
        for (n = 0; n < 20000 && dalm !== 1'b1; n++) @(posedge aclk);
        chk("dalm", 34'h1, {33'h0, dalm});
        rd(REG_STATUS, {RESP_OKAY, fbit | AUTO | 32'h1 << ST_DALM_BIT});
        rd(REG_IRQ_STAT, {RESP_OKAY, 32'h2});
        $display("test pulse done");
        stuck_a <= 1'b0;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        wr(REG_FUNC_SEL, code);
        wr(REG_DIAG_CFG, 32'h1 << DC_START_LSB);
        wr(REG_CTRL, 32'h1);
        for (int s = 0; s < 4; s++) begin
            close_a <= s != 0;
            close_b <= s != 2;
            repeat (4500) @(posedge aclk);
            chk("warn", {33'h0, s != 3}, {33'h0, warn});
        end
        rd(REG_STATUS, {RESP_OKAY, fbit});
        rd(REG_IRQ_STAT, {RESP_OKAY, 32'h4});
        $display("test restart done");
        close_out();
    end
endmodule : dual_channel_safety_input_test
